/* logic/l2fw_cfg.svh */
// Purpose: constants of the frame forwarder
// Assumes: 100 MHz ref_clk
// Notes:   definitions only
`ifndef L2FW_CFG_SVH
`define L2FW_CFG_SVH
`define L2FW_NPORTS       8
`define L2FW_CLK_NS       10
`define L2FW_CYC_PER_MS   (1000000 / `L2FW_CLK_NS)
`define L2FW_AGE_STEP_MS  75
`define L2FW_MIN_FRAME    14'h0040
`define L2FW_HW_MAX       14'h2400
`define L2FW_FCOE_ETYPE   16'h8906
`define L2FW_FIP_ETYPE    16'h8914
`define L2FW_BCAST        48'hFFFFFFFFFFFF
`define L2FW_TBL_ENTRIES  8
`define L2FW_TBL_CAP_KB   32
`define L2FW_FULL_PCT     90
`define L2FW_FULL_THRESH  ((`L2FW_TBL_ENTRIES * `L2FW_FULL_PCT) / 100)
`define L2FW_AGE_MAX      2'h3
`define L2FW_AGE_OLD      2'h2
`endif

/* logic/l2fw_pkg.sv */
// Purpose: shared types of the frame forwarder
// Assumes: nothing
// Notes:   constants live in l2fw_cfg.svh
package l2fw_pkg;
    typedef logic [47:0] l2fw_mac_t;
    typedef enum logic [2:0] {
        L2FW_PATH_L2,
        L2FW_PATH_FC_LOCAL,
        L2FW_PATH_FC_REMOTE,
        L2FW_PATH_FC_TRANSIT,
        L2FW_PATH_FC_EGRESS
    } l2fw_path_t;
endpackage : l2fw_pkg

/* logic/l2fw_fifo.sv */
// Purpose: small decision FIFO with valid/ready on both sides
// Assumes: depth a power of two
// Notes:   data out held in flip-flops of the store
`timescale 1ns/1ps
`default_nettype none
module l2fw_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0]  wp_r;
    logic [AW:0]  wp_nxt;
    logic [AW:0]  rp_r;
    logic [AW:0]  rp_nxt;
    logic         full;
    logic         empty;
    logic         push;
    logic         pop;

    // full when pointers differ only in the wrap bit
    assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign empty     = (wp_r == rp_r);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = mem_r[rp_r[AW-1:0]];

    ///////////////////////////////////////////////////////////////////
    // pointer next values
    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        if (!rst_n) begin
            wp_nxt = '0;
            rp_nxt = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        wp_r <= wp_nxt;
        rp_r <= rp_nxt;
    end

    // store needs no reset, empty flag guards reads
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule : l2fw_fifo
`default_nettype wire

/* logic/l2fw_core.sv */
// Purpose: layer 2 bridge and fcoe hop forwarder, one frame per cycle
// Assumes: descriptors and config come from logic on ref_clk
// Notes:   decisions queue in a 4 word FIFO ahead of the egress side
// How it works
// - unknown destination floods to same VLAN ports except ingress
// - known destination goes only to its recorded port
// - known destination on the ingress port is dropped
// - cut-through forwards bad checksum frames still marked bad
// - undersized frames are dropped and counted
// - overlong frames are cut, counted and sent with bad checksum
// - broadcast floods to same VLAN ports except ingress
// - expired entries are removed, so the address floods again
// - a station seen on a new port moves its entry there
// - near full, oldest aged entries are replaced; active ones stay
// - replacement starts at 7 of 8 entries, 90 percent of capacity rounded down
// - frames above the port max frame size but not overlong drop, per-port count
// - valid multicast floods when snooping is off
// - multicast with mismatched MAC and IP groups is dropped silently
// - fcoe looks up the fc destination; remote domains take the route
// - remote fcoe rewrites MACs to target and own forwarder MACs
// - remote fcoe gains a fabric header with own and target bridge
// - transit fcoe changes only the outer header
// - egress fcoe delivers to end node MAC and virtual port
// - fcoe passes only on the enabled fcoe VLAN
// - remote and transit fcoe spread over two equal cost uplinks; LAN traffic does not
// - fcoe ethertype 0x8906, init protocol 0x8914
`timescale 1ns/1ps
`default_nettype none
`include "l2fw_cfg.svh"
module l2fw_core #(
    parameter int unsigned AGE_CYCLES = `L2FW_AGE_STEP_MS * `L2FW_CYC_PER_MS
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [2:0]    in_port,
    input  wire logic [11:0]   in_vlan,
    input  wire logic [47:0]   in_dmac,
    input  wire logic [47:0]   in_smac,
    input  wire logic [15:0]   in_ethertype,
    input  wire logic [13:0]   in_len,
    input  wire logic          in_crc_ok,
    input  wire logic          in_mc_grp_match,
    input  wire logic          in_trill,
    input  wire logic [5:0]    in_trill_dst,
    input  wire logic [47:0]   in_inner_dmac,
    input  wire logic [23:0]   in_fc_dest_identifier,
    input  wire logic          cfg_cut_through,
    input  wire logic [111:0]  cfg_max_frame_size,
    input  wire logic [95:0]   cfg_port_vlan,
    input  wire logic          cfg_igmp_snoop,
    input  wire logic [11:0]   cfg_fcoe_vlan,
    input  wire logic          cfg_fcoe_en,
    input  wire logic [7:0]    cfg_my_domain,
    input  wire logic [5:0]    cfg_my_rbridge,
    input  wire logic [47:0]   cfg_fabric_forwarder_mac,
    input  wire logic [39:0]   cfg_fwd_mac_prefix,
    input  wire logic [23:0]   cfg_fc_map,
    input  wire logic [2:0]    cfg_uplink0,
    input  wire logic [2:0]    cfg_uplink1,
    input  wire logic          cfg_ecmp_en,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [7:0]         out_port_mask,
    output logic [47:0]        out_dmac,
    output logic [47:0]        out_smac,
    output logic               out_trill_add,
    output logic [5:0]         out_trill_src,
    output logic [5:0]         out_trill_dst,
    output logic               out_outer_only,
    output logic               out_bad_crc,
    output logic [13:0]        out_len,
    output logic [7:0]         out_end_node_virtual_port,
    output logic [15:0]        cnt_runt,
    output logic [15:0]        cnt_overlong,
    output logic [127:0]       cnt_oversize,
    output logic [3:0]         tbl_count
);
    localparam int NE = `L2FW_TBL_ENTRIES;
    localparam int NP = `L2FW_NPORTS;
    localparam int FW = 141;

    function automatic logic [7:0] l2fw_onehot(input logic [2:0] p);
        l2fw_onehot = 8'h01 << p;
    endfunction : l2fw_onehot

    ///////////////////////////////////////////////////////////////////
    // lookup table state
    logic                 tv_r   [NE];
    logic                 tv_nxt [NE];
    l2fw_pkg::l2fw_mac_t  tm_r   [NE];
    l2fw_pkg::l2fw_mac_t  tm_nxt [NE];
    logic [11:0]          tl_r   [NE];
    logic [11:0]          tl_nxt [NE];
    logic [2:0]           tp_r   [NE];
    logic [2:0]           tp_nxt [NE];
    logic [1:0]           ta_r   [NE];
    logic [1:0]           ta_nxt [NE];
    logic [31:0]          age_cnt_r;
    logic [31:0]          age_cnt_nxt;
    logic                 tick;

    // search and victim pick
    logic                 d_hit;
    logic                 s_hit;
    logic [2:0]           d_idx;
    logic [2:0]           s_idx;
    logic                 free_ok;
    logic [2:0]           free_idx;
    logic                 old_ok;
    logic [2:0]           old_idx;
    logic [1:0]           old_age;
    logic [3:0]           occ;
    logic                 vic_ok;
    logic [2:0]           vic_idx;

    // decision
    l2fw_pkg::l2fw_path_t path;
    logic                 acc;
    logic                 keep;
    logic                 push;
    logic                 learn;
    logic                 runt;
    logic                 ovl;
    logic                 ovs;
    logic                 bcast;
    logic                 mcast;
    logic                 fcoe_et;
    logic [13:0]          port_mtu;
    logic [7:0]           flood;
    logic [7:0]           ecmp_mask;
    logic [7:0]           mask;
    logic [47:0]          dmac_o;
    logic [47:0]          smac_o;
    logic                 trill_add;
    logic [5:0]           tsrc;
    logic [5:0]           tdst;
    logic                 outer;
    logic                 badcrc;
    logic [13:0]          len_o;
    logic [7:0]           vport;
    logic [FW-1:0]        fin;
    logic [FW-1:0]        fout;
    logic                 f_in_ready;

    // counters
    logic [15:0]          runt_r;
    logic [15:0]          runt_nxt;
    logic [15:0]          ovl_r;
    logic [15:0]          ovl_nxt;
    logic [15:0]          ovs_r   [NP];
    logic [15:0]          ovs_nxt [NP];

    assign in_ready     = f_in_ready;
    assign acc          = in_valid && f_in_ready;
    assign push         = acc && keep;
    assign cnt_runt     = runt_r;
    assign cnt_overlong = ovl_r;
    assign tbl_count    = occ;
    assign tick         = (age_cnt_r == AGE_CYCLES - 1);
    assign bcast        = (in_dmac == `L2FW_BCAST);
    assign mcast        = in_dmac[40] && !bcast;
    assign fcoe_et      = (in_ethertype == `L2FW_FCOE_ETYPE);
    assign port_mtu     = cfg_max_frame_size[in_port*14 +: 14];

    ///////////////////////////////////////////////////////////////////
    // flood set: same VLAN, never the ingress port
    for (genvar p = 0; p < NP; p++) begin : g_flood
        assign flood[p] = (cfg_port_vlan[p*12 +: 12] == in_vlan) &&
                          (in_port != 3'(p));
        assign cnt_oversize[p*16 +: 16] = ovs_r[p];
    end

    // two-way path spread on address bits, keeps a flow in order
    assign ecmp_mask = l2fw_onehot((cfg_ecmp_en &&
        ^(in_smac ^ in_dmac ^ {24'h000000, in_fc_dest_identifier})) ?
        cfg_uplink1 : cfg_uplink0);

    ///////////////////////////////////////////////////////////////////
    // table search, occupancy and replacement victim
    always_comb begin
        d_hit = 1'b0;
        s_hit = 1'b0;
        d_idx = 3'h0;
        s_idx = 3'h0;
        free_ok = 1'b0;
        free_idx = 3'h0;
        old_ok = 1'b0;
        old_idx = 3'h0;
        old_age = 2'h0;
        occ = 4'h0;
        for (int i = 0; i < NE; i++) begin
            if (tv_r[i] && tm_r[i] == in_dmac && tl_r[i] == in_vlan) begin
                d_hit = 1'b1;
                d_idx = 3'(i);
            end
            if (tv_r[i] && tm_r[i] == in_smac && tl_r[i] == in_vlan) begin
                s_hit = 1'b1;
                s_idx = 3'(i);
            end
            if (!tv_r[i] && !free_ok) begin
                free_ok = 1'b1;
                free_idx = 3'(i);
            end
            // only aged entries qualify, busy stations keep age 0
            if (tv_r[i] && ta_r[i] >= `L2FW_AGE_OLD &&
                (!old_ok || ta_r[i] > old_age)) begin
                old_ok = 1'b1;
                old_idx = 3'(i);
                old_age = ta_r[i];
            end
            occ = occ + {3'h0, tv_r[i]};
        end
        if (occ >= 4'(`L2FW_FULL_THRESH) && old_ok) begin
            vic_ok = 1'b1;
            vic_idx = old_idx;
        end else begin
            vic_ok = free_ok;
            vic_idx = free_idx;
        end
    end

    ///////////////////////////////////////////////////////////////////
    // forwarding decision for the presented frame
    always_comb begin
        path = l2fw_pkg::L2FW_PATH_L2;
        keep = 1'b1;
        runt = 1'b0;
        ovl = 1'b0;
        ovs = 1'b0;
        mask = 8'h00;
        dmac_o = in_dmac;
        smac_o = in_smac;
        trill_add = 1'b0;
        tsrc = 6'h00;
        tdst = 6'h00;
        outer = 1'b0;
        badcrc = !in_crc_ok;
        len_o = in_len;
        vport = 8'h00;
        if (in_len < `L2FW_MIN_FRAME) begin
            runt = 1'b1;
            keep = 1'b0;
        end else if (in_len > `L2FW_HW_MAX) begin
            ovl = 1'b1;
            len_o = `L2FW_HW_MAX;
            badcrc = 1'b1;
        end else if (in_len > port_mtu) begin
            ovs = 1'b1;
            keep = 1'b0;
        end
        // store and forward has the whole frame, so bad ones stop here
        if (!in_crc_ok && !cfg_cut_through) begin
            keep = 1'b0;
        end
        if (fcoe_et) begin
            if (!cfg_fcoe_en || in_vlan != cfg_fcoe_vlan) begin
                keep = 1'b0;
            end else if (in_trill && in_trill_dst != cfg_my_rbridge) begin
                path = l2fw_pkg::L2FW_PATH_FC_TRANSIT;
                outer = 1'b1;
                tdst = in_trill_dst;
                mask = ecmp_mask;
            end else if (in_trill) begin
                path = l2fw_pkg::L2FW_PATH_FC_EGRESS;
                keep = keep && (in_inner_dmac == cfg_fabric_forwarder_mac);
                dmac_o = {cfg_fc_map, in_fc_dest_identifier};
                smac_o = cfg_fabric_forwarder_mac;
                vport = in_fc_dest_identifier[7:0];
                mask = l2fw_onehot(in_fc_dest_identifier[10:8]);
            end else if (in_fc_dest_identifier[23:16] == cfg_my_domain) begin
                path = l2fw_pkg::L2FW_PATH_FC_LOCAL;
                keep = keep && (in_dmac == cfg_fabric_forwarder_mac);
                dmac_o = {cfg_fc_map, in_fc_dest_identifier};
                smac_o = cfg_fabric_forwarder_mac;
                vport = in_fc_dest_identifier[7:0];
                mask = l2fw_onehot(in_fc_dest_identifier[10:8]);
            end else begin
                path = l2fw_pkg::L2FW_PATH_FC_REMOTE;
                keep = keep && (in_dmac == cfg_fabric_forwarder_mac);
                dmac_o = {cfg_fwd_mac_prefix,
                          in_fc_dest_identifier[23:16]};
                smac_o = cfg_fabric_forwarder_mac;
                trill_add = 1'b1;
                tsrc = cfg_my_rbridge;
                tdst = in_fc_dest_identifier[21:16];
                mask = ecmp_mask;
            end
        end else if (bcast) begin
            mask = flood;
        end else if (mcast) begin
            // no group table: snooping on or off, valid groups flood
            if (!in_mc_grp_match) begin
                keep = 1'b0;
            end else begin
                mask = flood;
            end
        end else if (d_hit) begin
            if (tp_r[d_idx] == in_port) begin
                keep = 1'b0;
            end else begin
                mask = l2fw_onehot(tp_r[d_idx]);
            end
        end else begin
            mask = flood;
        end
        // init protocol frames bridge as layer 2 and are learned even with a bad checksum
        learn = !fcoe_et && !runt && !ovs && !in_smac[40] &&
                (in_crc_ok || in_ethertype == `L2FW_FIP_ETYPE);
    end

    ///////////////////////////////////////////////////////////////////
    // table and aging next state
    always_comb begin
        age_cnt_nxt = tick ? 32'h0 : age_cnt_r + 32'h1;
        for (int i = 0; i < NE; i++) begin
            tv_nxt[i] = tv_r[i];
            tm_nxt[i] = tm_r[i];
            tl_nxt[i] = tl_r[i];
            tp_nxt[i] = tp_r[i];
            ta_nxt[i] = ta_r[i];
            if (tick && tv_r[i]) begin
                if (ta_r[i] == `L2FW_AGE_MAX) begin
                    tv_nxt[i] = 1'b0;
                end else begin
                    ta_nxt[i] = ta_r[i] + 2'h1;
                end
            end
        end
        // traffic to a station keeps its entry young
        if (push && d_hit && path == l2fw_pkg::L2FW_PATH_L2) begin
            ta_nxt[d_idx] = 2'h0;
        end
        if (acc && learn) begin
            if (s_hit) begin
                tv_nxt[s_idx] = 1'b1;
                tp_nxt[s_idx] = in_port;
                ta_nxt[s_idx] = 2'h0;
            end else if (vic_ok) begin
                tv_nxt[vic_idx] = 1'b1;
                tm_nxt[vic_idx] = in_smac;
                tl_nxt[vic_idx] = in_vlan;
                tp_nxt[vic_idx] = in_port;
                ta_nxt[vic_idx] = 2'h0;
            end
        end
        if (!rst_n) begin
            age_cnt_nxt = 32'h0;
            for (int i = 0; i < NE; i++) begin
                tv_nxt[i] = 1'b0;
                ta_nxt[i] = 2'h0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        age_cnt_r <= age_cnt_nxt;
        tv_r <= tv_nxt;
        tm_r <= tm_nxt;
        tl_r <= tl_nxt;
        tp_r <= tp_nxt;
        ta_r <= ta_nxt;
    end

    ///////////////////////////////////////////////////////////////////
    // error counters, wrap at full scale
    always_comb begin
        runt_nxt = (acc && runt) ? runt_r + 16'h0001 : runt_r;
        ovl_nxt = (acc && ovl) ? ovl_r + 16'h0001 : ovl_r;
        for (int p = 0; p < NP; p++) begin
            ovs_nxt[p] = (acc && ovs && in_port == 3'(p)) ?
                         ovs_r[p] + 16'h0001 : ovs_r[p];
        end
        if (!rst_n) begin
            runt_nxt = 16'h0000;
            ovl_nxt = 16'h0000;
            for (int p = 0; p < NP; p++) begin
                ovs_nxt[p] = 16'h0000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        runt_r <= runt_nxt;
        ovl_r <= ovl_nxt;
        ovs_r <= ovs_nxt;
    end

    ///////////////////////////////////////////////////////////////////
    // decision queue; a stalled egress stops intake
    assign fin = {mask, dmac_o, smac_o, trill_add, tsrc, tdst, outer,
                  badcrc, len_o, vport};
    assign {out_port_mask, out_dmac, out_smac, out_trill_add,
            out_trill_src, out_trill_dst, out_outer_only, out_bad_crc,
            out_len, out_end_node_virtual_port} = fout;

    l2fw_fifo #(
        .W     (FW),
        .DEPTH (4)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (f_in_ready),
        .in_data   (fin),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fout)
    );

    ///////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_flood_miss;
        acc && !fcoe_et && !mcast && !bcast && !d_hit && keep |-> fin[140:133] == flood;
    endproperty
    a_flood_miss: assert property (p_flood_miss) else $error("miss not flooded");

    property p_hairpin;
        acc && !fcoe_et && !mcast && !bcast && d_hit && tp_r[d_idx] == in_port |-> !push;
    endproperty
    a_hairpin: assert property (p_hairpin) else $error("hairpin not dropped");

    property p_runt_count;
        acc && runt |=> cnt_runt == $past(cnt_runt) + 16'h0001;
    endproperty
    a_runt_count: assert property (p_runt_count) else $error("runt count");

    property p_trunc;
        push && in_len > `L2FW_HW_MAX |-> fin[22] && fin[21:8] == `L2FW_HW_MAX
            ##1 cnt_overlong == $past(cnt_overlong) + 16'h0001;
    endproperty
    a_trunc: assert property (p_trunc) else $error("overlong handling");

    property p_mc_mismatch;
        acc && !fcoe_et && mcast && !in_mc_grp_match |-> !push;
    endproperty
    a_mc_mismatch: assert property (p_mc_mismatch) else $error("mc kept");

    property p_fcoe_vlan;
        push && fcoe_et |-> cfg_fcoe_en && in_vlan == cfg_fcoe_vlan;
    endproperty
    a_fcoe_vlan: assert property (p_fcoe_vlan) else $error("fcoe vlan");

    property p_remote_rewrite;
        push && path == l2fw_pkg::L2FW_PATH_FC_REMOTE |->
            smac_o == cfg_fabric_forwarder_mac && trill_add && tsrc == cfg_my_rbridge;
    endproperty
    a_remote_rewrite: assert property (p_remote_rewrite) else $error("remote hdr");

    property p_learn;
        acc && learn && !s_hit && vic_ok |=> tv_r[$past(vic_idx)] && tp_r[$past(vic_idx)] == $past(in_port);
    endproperty
    a_learn: assert property (p_learn) else $error("not learned");

    property p_push_out;
        push && !out_valid |=> out_valid && out_port_mask == $past(mask);
    endproperty
    a_push_out: assert property (p_push_out) else $error("decision lost");

    property p_expire;
        tick && tv_r[0] && ta_r[0] == `L2FW_AGE_MAX && !(acc && learn) |=> !tv_r[0];
    endproperty
    a_expire: assert property (p_expire) else $error("no expiry");
endmodule : l2fw_core
`default_nettype wire

/* sim/l2fw_sink.sv */
// Purpose: egress side model that takes forwarding decisions
// Assumes: decision word held stable while out_valid
// Notes:   stall backs the decision FIFO up
`timescale 1ns/1ps
`default_nettype none
module l2fw_sink (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic stall,
    output var  logic out_ready
);
    ////////////////////////////////////////
    // changes just after the edge; stall comes at negedge
    initial out_ready = 1'b0;
    always @(posedge ref_clk) begin
        out_ready <= rst_n && !stall;
    end
endmodule : l2fw_sink
`default_nettype wire

/* sim/l2_bridge_fcoe_forwarder_tb.sv */
// Purpose: self-checking bench of the frame forwarder
// Assumes: l2fw_sink drains decisions unless stalled
// Notes:   short aging step so idle entries expire fast
`timescale 1ns/1ps
`default_nettype none
module l2_bridge_fcoe_forwarder_tb;
    typedef struct {
        logic [2:0]  p;
        logic [1:0]  k;
        logic [7:0]  d, s;
        logic [13:0] l;
        logic        ok, mg, v;
        logic [7:0]  m;
    } l2fw_row_t;
    localparam logic [47:0] MY = 48'h0E0000000001;
    localparam logic [39:0] UB = 40'h0200000000;
    logic ref_clk = 1'b0, rst_n = 1'b0, in_valid = 1'b0, stall = 1'b0;
    logic in_crc_ok = 1'b1, in_mc_grp_match = 1'b1, in_trill = 1'b0;
    logic cfg_cut_through = 1'b1, cfg_igmp_snoop = 1'b0;
    logic cfg_fcoe_en = 1'b1, cfg_ecmp_en = 1'b0;
    logic [2:0] in_port = 3'h0, cfg_uplink0 = 3'h7, cfg_uplink1 = 3'h1;
    logic [5:0] in_trill_dst = 6'h01, cfg_my_rbridge = 6'h01;
    logic [11:0] in_vlan = 12'h001, cfg_fcoe_vlan = 12'h001;
    logic [47:0] in_dmac = '0, in_smac = '0, in_inner_dmac = MY, dm;
    logic [47:0] cfg_fabric_forwarder_mac = MY;
    logic [15:0] in_ethertype = 16'h0800;
    logic [13:0] in_len = 14'h0040;
    logic [23:0] in_fc_dest_identifier = '0, cfg_fc_map = 24'h0EFC00;
    logic [7:0] cfg_my_domain = 8'h01;
    logic [39:0] cfg_fwd_mac_prefix = 40'h0E000000AA;
    logic [111:0] cfg_max_frame_size = {{3{14'h2400}}, 14'h05EE,
                                        {4{14'h2400}}};
    logic [95:0] cfg_port_vlan = {12'h001, 12'h002, {6{12'h001}}};
    logic in_ready, out_valid, out_ready, out_trill_add;
    logic out_outer_only, out_bad_crc;
    logic [7:0] out_port_mask, out_end_node_virtual_port;
    logic [47:0] out_dmac, out_smac;
    logic [5:0] out_trill_src, out_trill_dst;
    logic [13:0] out_len;
    logic [15:0] cnt_runt, cnt_overlong;
    logic [127:0] cnt_oversize;
    logic [3:0] tbl_count;
    int err_total = 0, n_compared = 0, i, k;
    // port 6 sits alone in vlan 2, so floods from vlan 1 skip it
    l2fw_row_t rows [11] = '{
        '{3'h0, 2'h0, 8'h0A, 8'h0B, 14'h0100, 1'h1, 1'h1, 1'h1, 8'hBE},
        '{3'h1, 2'h0, 8'h0B, 8'h0A, 14'h0100, 1'h1, 1'h1, 1'h1, 8'h01},
        '{3'h1, 2'h0, 8'h0A, 8'h0C, 14'h0100, 1'h1, 1'h1, 1'h0, 8'h00},
        '{3'h2, 2'h1, 8'h00, 8'h0D, 14'h0100, 1'h1, 1'h1, 1'h1, 8'hBB},
        '{3'h3, 2'h0, 8'h0E, 8'h0A, 14'h0100, 1'h1, 1'h1, 1'h1, 8'hB7},
        '{3'h0, 2'h0, 8'h0A, 8'h0B, 14'h0100, 1'h1, 1'h1, 1'h1, 8'h08},
        '{3'h2, 2'h0, 8'h0A, 8'h0F, 14'h0100, 1'h0, 1'h1, 1'h1, 8'h08},
        '{3'h5, 2'h2, 8'h01, 8'h11, 14'h0100, 1'h1, 1'h0, 1'h0, 8'h00},
        '{3'h5, 2'h2, 8'h01, 8'h11, 14'h0100, 1'h1, 1'h1, 1'h1, 8'h9F},
        '{3'h6, 2'h0, 8'h0A, 8'h12, 14'h0020, 1'h1, 1'h1, 1'h0, 8'h00},
        '{3'h4, 2'h0, 8'h0A, 8'h13, 14'h0800, 1'h1, 1'h1, 1'h0, 8'h00}};
    l2fw_core #(.AGE_CYCLES(200)) i_dut (.*);
    l2fw_sink i_sink (.*);
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [127:0] e, g);
        n_compared++;
        if (g !== e) begin
            $display("wrong value %s exp %0h got %0h", n, e, g);
            err_total++;
        end
    endtask : chk
    // holds the descriptor until an edge sees in_ready high
    task automatic send(input logic [2:0] p, input logic [47:0] d, s,
                        input logic [13:0] l);
        @(negedge ref_clk);
        {in_port, in_dmac, in_smac, in_len} = {p, d, s, l};
        in_valid = 1'b1;
        for (k = 0; k < 50 && in_ready !== 1'b1; k++) @(negedge ref_clk);
        if (k == 50) err_total++;
        @(negedge ref_clk);
        in_valid = 1'b0;
    endtask : send
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////
    // clock and watchdog
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk("idle", 21'h0, {out_valid, tbl_count, cnt_runt});
        for (i = 0; i < 11; i++) begin
            in_crc_ok = rows[i].ok;
            in_mc_grp_match = rows[i].mg;
            dm = {rows[i].k[1] ? 40'h01005E0000 : UB, rows[i].d};
            if (rows[i].k == 2'h1) dm = 48'hFFFFFFFFFFFF;
            send(rows[i].p, dm, {UB, rows[i].s}, rows[i].l);
            chk("valid", rows[i].v, out_valid);
            if (rows[i].v) begin
                chk("mask", rows[i].m, out_port_mask);
                chk("bad", !rows[i].ok, out_bad_crc);
            end
            $display("test row %0d done", i);
        end
        in_crc_ok = 1'b1;
        in_mc_grp_match = 1'b1;
        chk("runt", 16'h0001, cnt_runt);
        chk("oversize", 16'h0001, cnt_oversize[64+:16]);
        send(3'h7, {UB, 8'h0A}, {UB, 8'h14}, 14'h3000);
        chk("len", {14'h2400, 1'b1}, {out_len, out_bad_crc});
        chk("overlong", 16'h0001, cnt_overlong);
        $display("test errors done");
        in_ethertype = 16'h8906;
        in_fc_dest_identifier = 24'h030100;
        send(3'h2, MY, {UB, 8'h21}, 14'h0100);
        chk("dmac", {40'h0E000000AA, 8'h03}, out_dmac);
        chk("smac", MY, out_smac);
        chk("hdr", 13'h1043, {out_trill_add, out_trill_src, out_trill_dst});
        chk("mask", 8'h80, out_port_mask);
        in_fc_dest_identifier = 24'h010542;
        for (i = 0; i < 2; i++) begin
            in_trill = i[0];
            send(3'h2, i ? {UB, 8'h99} : MY, {UB, 8'h22}, 14'h0100);
            chk("dmac", 48'h0EFC00010542, out_dmac);
            chk("vport", 16'h4220, {out_end_node_virtual_port,
                                    out_port_mask});
        end
        in_trill_dst = 6'h05;
        send(3'h2, {UB, 8'h99}, {UB, 8'h22}, 14'h0100);
        chk("transit", 15'h4580, {out_outer_only, out_trill_dst,
                                  out_port_mask});
        in_trill = 1'b0;
        cfg_fcoe_en = 1'b0;
        send(3'h2, MY, {UB, 8'h21}, 14'h0100);
        chk("valid", 1'b0, out_valid);
        cfg_fcoe_en = 1'b1;
        in_vlan = 12'h002;
        send(3'h2, MY, {UB, 8'h21}, 14'h0100);
        chk("valid", 1'b0, out_valid);
        in_vlan = 12'h001;
        in_ethertype = 16'h0800;
        $display("test fcoe done");
        repeat (1200) @(negedge ref_clk);
        chk("count", 4'h0, tbl_count);
        send(3'h1, {UB, 8'h0B}, {UB, 8'h30}, 14'h0100);
        chk("mask", 8'hBD, out_port_mask);
        for (i = 0; i < 9; i++) send(3'h2, '1, {UB, 8'h40 + i[7:0]}, 14'h0100);
        chk("count", 4'h8, tbl_count);
        send(3'h1, {UB, 8'h40}, {UB, 8'h30}, 14'h0100);
        chk("mask", 8'h04, out_port_mask);
        $display("test table done");
        stall = 1'b1;
        for (i = 0; i < 4; i++) send(3'h0, '1, {UB, 8'h40}, 14'h0100);
        chk("full", 2'h1, {in_ready, out_valid});
        stall = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk("empty", 2'h2, {in_ready, out_valid});
        $display("test fifo done");
        give_verdict();
    end
endmodule : l2_bridge_fcoe_forwarder_tb
`default_nettype wire
